// *** rtl/nco_pkg.sv ***
// Purpose: constants for the numerically controlled oscillator block
// Assumes: 32-bit APB, one register per aligned word
// Notes:   byte registers sit in the low bits, upper bits read as zero
package nco_pkg;
    localparam int unsigned NCO_ACC_W   = 20;
    localparam int unsigned NCO_PCLK_HZ = 40_000_000;

    // register byte addresses
    localparam logic [7:0] NCO_ADDR_CTRL  = 8'h00;
    localparam logic [7:0] NCO_ADDR_CLK   = 8'h04;
    localparam logic [7:0] NCO_ADDR_ACCL  = 8'h08;
    localparam logic [7:0] NCO_ADDR_ACCH  = 8'h0C;
    localparam logic [7:0] NCO_ADDR_ACCU  = 8'h10;
    localparam logic [7:0] NCO_ADDR_INCL  = 8'h14;
    localparam logic [7:0] NCO_ADDR_INCH  = 8'h18;
    localparam logic [7:0] NCO_ADDR_INCU  = 8'h1C;
    localparam logic [7:0] NCO_ADDR_FLAG  = 8'h20;
    localparam logic [7:0] NCO_ADDR_IEN   = 8'h24;

    // oscillator_control fields
    localparam int unsigned NCO_CTRL_EN   = 7;
    localparam int unsigned NCO_CTRL_OUT  = 5;
    localparam int unsigned NCO_CTRL_POL  = 4;
    localparam int unsigned NCO_CTRL_PFM  = 0;
    // input_clock_control fields
    localparam int unsigned ACCUMULATOR_INPUT_CLOCK_PWS_LO = 5;
    localparam int unsigned ACCUMULATOR_INPUT_CLOCK_PWS_HI = 7;
    localparam int unsigned ACCUMULATOR_INPUT_CLOCK_CKS_LO = 0;
    localparam int unsigned ACCUMULATOR_INPUT_CLOCK_CKS_HI = 1;
    // flag and enable register fields
    localparam int unsigned NCO_FLAG_OVF  = 0;
    localparam int unsigned NCO_IEN_OVF   = 0;
    localparam int unsigned NCO_IEN_PER   = 1;
    localparam int unsigned NCO_IEN_GLB   = 2;

    localparam logic [7:0] NCO_BYTE_RST   = 8'h00;
    localparam logic [1:0] NCO_LOAD_DLY   = 2'h2;

    typedef enum logic [1:0] {
        NCO_SRC_FAST  = 2'b00,
        NCO_SRC_SYS   = 2'b01,
        NCO_SRC_CELL  = 2'b10,
        NCO_SRC_RSVD  = 2'b11
    } nco_src_type;
endpackage

// *** rtl/nco_top.sv ***
// Purpose: 20-bit phase accumulator frequency generator with APB registers
// Assumes: source clocks are well below pclk/2; they are sampled, not used
//          as clocks, so every rising edge of the selected source becomes a one-cycle tick while en is set
// Notes:   sleep needs only fast_osc_keep here: the block never waits on the cpu
//          register map, one byte register per aligned 32-bit word:
//            0x00 oscillator_control   en, out (ro), polarity, mode
//            0x04 input_clock_control  pulse width code, source code
//            0x08 0x0C 0x10            accumulator low, high, upper
//            0x14 0x18 0x1C            increment low, high, upper
//            0x20 overflow_interrupt_flag, write zero clears
//            0x24 interrupt enables: overflow, peripheral, global
//          every unmapped or unaligned access answers with pslverr
//          and reads as zero unless its low address byte names a register; writes there are dropped
//          the hidden increment buffer has no address at all
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module nco_top
    import nco_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fast_osc_in,
    input  wire logic        sys_osc_in,
    input  wire logic        cell_in,
    output logic             wave_out,
    output logic             pin_out,
    output logic             fast_osc_keep,
    output logic             irq
);
    localparam int unsigned W = NCO_ACC_W;

    // pulse width minus one, in input periods
    function automatic logic [7:0] width_m1(input logic [2:0] code);
        width_m1 = (8'h01 << code) - 8'h01;
    endfunction

    // unpacked so each synchroniser process owns its own element
    logic [1:0]      sync_r [0:2];
    logic            src_d_r;
    logic [7:0]      ctrl_r;
    logic [7:0]      clk_r;
    logic [W-1:0]    acc_r;
    logic [W-1:0]    inc_r;
    logic [W-1:0]    incbuf_r;
    logic [1:0]      load_cnt_r;
    logic            toggle_r;
    logic            pulse_r;
    logic [7:0]      pcnt_r;
    logic            flag_r;
    logic [2:0]      ien_r;
    logic [31:0]     prdata_r;

    // source pins are asynchronous: two flops each
    // all three sources are synchronised all the time, so a change of
    // source select never sees a stale first-stage value; the cost is
    // a few idle flops on the unselected paths
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic src_pin;
            if (gi == 0) begin : g_f
                assign src_pin = fast_osc_in;
            end else if (gi == 1) begin : g_s
                assign src_pin = sys_osc_in;
            end else begin : g_c
                assign src_pin = cell_in;
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_r[gi] <= 2'h0;
                end else begin
                    sync_r[gi] <= {sync_r[gi][0], src_pin};
                end
            end
        end
    endgenerate

    wire         en      = ctrl_r[NCO_CTRL_EN];
    wire         pol     = ctrl_r[NCO_CTRL_POL];
    wire         pfm     = ctrl_r[NCO_CTRL_PFM];
    wire [2:0]   pws     = clk_r[ACCUMULATOR_INPUT_CLOCK_PWS_HI:ACCUMULATOR_INPUT_CLOCK_PWS_LO];
    wire nco_src_type cks = nco_src_type'(clk_r[ACCUMULATOR_INPUT_CLOCK_CKS_HI:ACCUMULATOR_INPUT_CLOCK_CKS_LO]);

    wire src_lvl = (cks == NCO_SRC_FAST) ? sync_r[0][1] :
                   (cks == NCO_SRC_SYS)  ? sync_r[1][1] :
                   (cks == NCO_SRC_CELL) ? sync_r[2][1] : 1'b0;
    // edge flop resets low, matching the idle level of a stopped
    // source; a source that idles high gives one tick after reset,
    // which is harmless because the module is still disabled then
    wire src_rise = src_lvl & ~src_d_r;
    wire tick = src_rise & en;

    wire [W:0] sum   = {1'b0, acc_r} + {1'b0, incbuf_r};
    wire       ovf   = tick & sum[W];

    // APB decode
    // no wait states: writes land at the access edge, and read data is
    // captured at the setup edge so it stands through the access phase
    // a read therefore shows the state one cycle before the access
    wire        setup  = psel & ~penable;
    wire        wr     = psel & penable & pwrite;
    wire [7:0]  a      = paddr[7:0];
    wire        mapped = (paddr[31:8] == 24'h000000) && (a[1:0] == 2'b00)
                         && (a <= NCO_ADDR_IEN);
    wire        wr_ok  = wr & mapped;
    wire        w_ctrl = wr_ok && (a == NCO_ADDR_CTRL);
    wire        w_clk  = wr_ok && (a == NCO_ADDR_CLK);
    wire        w_accl = wr_ok && (a == NCO_ADDR_ACCL);
    wire        w_acch = wr_ok && (a == NCO_ADDR_ACCH);
    wire        w_accu = wr_ok && (a == NCO_ADDR_ACCU);
    wire        w_incl = wr_ok && (a == NCO_ADDR_INCL);
    wire        w_inch = wr_ok && (a == NCO_ADDR_INCH);
    wire        w_incu = wr_ok && (a == NCO_ADDR_INCU);
    wire        w_flag = wr_ok && (a == NCO_ADDR_FLAG);
    wire        w_ien  = wr_ok && (a == NCO_ADDR_IEN);
    wire [7:0]  wb     = pwdata[7:0];

    wire pol_evt = w_ctrl && (wb[NCO_CTRL_POL] != pol) && ien_r[NCO_IEN_OVF];

    wire raw_out = pfm ? pulse_r : toggle_r;
    wire fin_out = raw_out ^ pol;

    wire [7:0] ctrl_rd = {ctrl_r[7:6], fin_out, ctrl_r[4:0]};

    // read mux; unimplemented bits of each byte read as zero
    wire [7:0] rd_byte =
        (a == NCO_ADDR_CTRL) ? ctrl_rd :
        (a == NCO_ADDR_CLK)  ? clk_r :
        (a == NCO_ADDR_ACCL) ? acc_r[7:0] :
        (a == NCO_ADDR_ACCH) ? acc_r[15:8] :
        (a == NCO_ADDR_ACCU) ? {4'h0, acc_r[19:16]} :
        (a == NCO_ADDR_INCL) ? inc_r[7:0] :
        (a == NCO_ADDR_INCH) ? inc_r[15:8] :
        (a == NCO_ADDR_INCU) ? {4'h0, inc_r[19:16]} :
        (a == NCO_ADDR_FLAG) ? {7'h00, flag_r} :
        (a == NCO_ADDR_IEN)  ? {5'h00, ien_r} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_d_r  <= 1'b0;
            ctrl_r   <= NCO_BYTE_RST;
            clk_r    <= NCO_BYTE_RST;
            ien_r    <= 3'h0;
            prdata_r <= 32'h0000_0000;
        end else begin
            src_d_r <= src_lvl;
            // enable bit writable, unused bits stay zero
            if (w_ctrl) begin
                ctrl_r <= {wb[NCO_CTRL_EN], 2'b00, wb[NCO_CTRL_POL],
                           3'b000, wb[NCO_CTRL_PFM]};
            end
            if (w_clk) begin
                clk_r <= {wb[7:5], 3'b000, wb[1:0]};
            end
            if (w_ien) begin
                ien_r <= wb[2:0];
            end
            if (setup) begin
                prdata_r <= {24'h000000, rd_byte};
            end
        end
    end

    // software writes win over a tick; undefined if running
    logic [W-1:0] acc_nxt;
    always_comb begin
        acc_nxt = tick ? sum[W-1:0] : acc_r;
        if (w_accl) begin
            acc_nxt[7:0] = wb;
        end
        if (w_acch) begin
            acc_nxt[15:8] = wb;
        end
        if (w_accu) begin
            acc_nxt[19:16] = wb[3:0];
        end
    end

    logic [W-1:0] inc_nxt;
    always_comb begin
        inc_nxt = inc_r;
        if (w_incl) begin
            inc_nxt[7:0] = wb;
        end
        if (w_inch) begin
            inc_nxt[15:8] = wb;
        end
        if (w_incu) begin
            inc_nxt[19:16] = wb[3:0];
        end
    end

    // double buffer: the adder only ever sees incbuf_r, so a partly
    // written increment never reaches it while the module runs;
    // software must finish upper and high before touching low
    wire inc_wr   = w_incl | w_inch | w_incu;
    // second input edge after a low-byte write
    wire load_now = tick && (load_cnt_r == 2'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r      <= '0;
            inc_r      <= '0;
            incbuf_r   <= '0;
            load_cnt_r <= 2'h0;
        end else begin
            acc_r <= acc_nxt;
            inc_r <= inc_nxt;
            // disabled: buffer follows writes at once
            if (!en && inc_wr) begin
                incbuf_r <= inc_nxt;
            end else if (load_now) begin
                incbuf_r <= inc_r;
            end
            // arm on low-byte write, count input edges
            if (en && w_incl) begin
                load_cnt_r <= NCO_LOAD_DLY;
            end else if (!en) begin
                load_cnt_r <= 2'h0;
            end else if (tick && load_cnt_r != 2'h0) begin
                load_cnt_r <= load_cnt_r - 2'h1;
            end
        end
    end

    // output stages; pulse counter restarts on overlap so output stays put
    // pcnt_r counts remaining input periods after the start tick; a
    // width of 2^code ticks ends on the tick where the count is zero
    // the toggle and pulse paths both run; the mode bit only picks one
    // at the output, so switching modes shows the other path at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_r <= 1'b0;
            pulse_r  <= 1'b0;
            pcnt_r   <= 8'h00;
        end else begin
            if (ovf) begin
                toggle_r <= ~toggle_r;
            end
            if (ovf) begin
                pulse_r <= 1'b1;
                pcnt_r  <= width_m1(pws);
            end else if (tick && pulse_r) begin
                if (pcnt_r == 8'h00) begin
                    pulse_r <= 1'b0;
                end else begin
                    pcnt_r <= pcnt_r - 8'h01;
                end
            end
        end
    end

    // a polarity flip with the overflow enable set sets the same flag as an overflow; software can
    // not tell them apart, which matches the single flag bit
    // overflow sets flag
    // held until software writes zero; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else if (ovf || pol_evt) begin
            flag_r <= 1'b1;
        end else if (w_flag && !wb[NCO_FLAG_OVF]) begin
            flag_r <= 1'b0;
        end
    end

    assign prdata  = prdata_r;
    // every register answers at once, so ready never drops
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    // mode bit selects pulse or fixed duty
    // final output to peripherals and pin
    assign wave_out = fin_out;
    assign pin_out  = fin_out;
    // hold fast oscillator on in sleep
    // no sleep input: block runs whenever its source runs
    assign fast_osc_keep = en && (cks == NCO_SRC_FAST);
    assign irq = flag_r & en & ien_r[NCO_IEN_OVF] & ien_r[NCO_IEN_PER]
                 & ien_r[NCO_IEN_GLB];
endmodule

// *** tb/nco_checker.sv ***
// Purpose: port-level assertions for nco_top
// Assumes: control, clock and enable bytes are mirrored from apb writes
// Notes:   the mirror sees only what software wrote, not internal state
`timescale 1ns/1ps
module nco_chk
    import nco_pkg::*;
(
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        fast_osc_in,
    input logic        sys_osc_in,
    input logic        cell_in,
    input logic        wave_out,
    input logic        pin_out,
    input logic        fast_osc_keep,
    input logic        irq
);
    logic [7:0] ctl_r;
    logic [7:0] clk_r;
    logic [7:0] ien_r;
    wire        acc_go = psel & penable;
    wire        wr_go  = acc_go & pwrite;
    wire  [7:0] ad     = paddr[7:0];
    wire        en     = ctl_r[NCO_CTRL_EN];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 8'h00;
            clk_r <= 8'h00;
            ien_r <= 8'h00;
        end else if (wr_go) begin
            if (ad == NCO_ADDR_CTRL) ctl_r <= pwdata[7:0];
            if (ad == NCO_ADDR_CLK) clk_r <= pwdata[7:0];
            if (ad == NCO_ADDR_IEN) ien_r <= pwdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; pready; endproperty
    property p_pin; pin_out == wave_out; endproperty
    property p_err_idle; !acc_go |-> !pslverr; endproperty
    property p_err_map; acc_go && ad == 8'h28 |-> pslverr; endproperty
    property p_rd_hi; prdata[31:8] == 24'h0; endproperty
    property p_keep;
        fast_osc_keep == (en && clk_r[1:0] == 2'h0);
    endproperty
    property p_irq; irq |-> en && ien_r[2:0] == 3'h7; endproperty
    // no write and disabled: the output may not move
    property p_hold; !en && !wr_go |=> $stable(wave_out); endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_pin: assert property (p_pin) else $error("pin differs");
    // share the final output; pin copy must match it
    a_err_idle: assert property (p_err_idle) else $error("stray pslverr");
    a_err_map: assert property (p_err_map) else $error("no pslverr");
    a_rd_hi: assert property (p_rd_hi) else $error("prdata high bits");
    a_keep: assert property (p_keep) else $error("keep wrong");
    a_irq: assert property (p_irq) else $error("irq ungated");
    a_hold: assert property (p_hold) else $error("moved idle");

    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_pulse: cover property ($rose(wave_out));
endmodule

bind nco_top nco_chk u_nco_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fast_osc_in(fast_osc_in),
    .sys_osc_in(sys_osc_in), .cell_in(cell_in), .wave_out(wave_out),
    .pin_out(pin_out), .fast_osc_keep(fast_osc_keep), .irq(irq)
);

// *** tb/testbench.sv ***
// Purpose: register-level tests of nco_top over apb
// Assumes: a source pulse of 4 pclk high, 4 low gives exactly one tick
// Notes:   accumulator is only written while the module is disabled
`timescale 1ns/1ps
module testbench;
    import nco_pkg::*;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic        fast_osc_in = 1'h0;
    logic        sys_osc_in = 1'h0;
    logic        cell_in = 1'h0;
    wire  [31:0] prdata;
    wire         pready, pslverr, wave_out, pin_out, fast_osc_keep, irq;
    int          mismatches = 0;
    int          checks_done = 0;
    int          n, cnt;
    logic  [7:0] a;

    always #12.5 pclk = ~pclk;

    nco_top u_nco_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fast_osc_in(fast_osc_in),
        .sys_osc_in(sys_osc_in), .cell_in(cell_in), .wave_out(wave_out),
        .pin_out(pin_out), .fast_osc_keep(fast_osc_keep), .irq(irq)
    );

    task report_and_stop;
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t saw %h want %h", $time, s, e);
        end
    endtask

    task xf(input logic w, input logic [7:0] ad, input logic [7:0] d,
            output logic [7:0] v);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {24'h0, ad};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        v = prdata[7:0];
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [7:0] ad, input logic [7:0] d);
        logic [7:0] v;
        xf(1'h1, ad, d, v);
    endtask

    task rc(input logic [7:0] ad, input logic [7:0] e);
        logic [7:0] v;
        xf(1'h0, ad, 8'h00, v);
        chk(v, e);
    endtask

    // one pulse on each source named in the mask
    task tk(input logic [2:0] m);
        @(posedge pclk);
        {cell_in, sys_osc_in, fast_osc_in} <= m;
        repeat (4) @(posedge pclk);
        {cell_in, sys_osc_in, fast_osc_in} <= 3'h0;
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        for (n = 0; n < 10; n++) rc(8'(4 * n), 8'h00);
        rc(8'h28, 8'h00);
        wr(NCO_ADDR_ACCU, 8'hFF);
        rc(NCO_ADDR_ACCU, 8'h0F);
        wr(NCO_ADDR_INCH, 8'hA5);
        rc(NCO_ADDR_INCH, 8'hA5);
        tk(3'h7);
        rc(NCO_ADDR_ACCU, 8'h0F);
        for (n = 0; n < 4; n++) begin
            wr(NCO_ADDR_CTRL, 8'h00);
            wr(NCO_ADDR_ACCU, 8'h00);
            wr(NCO_ADDR_ACCL, 8'h00);
            wr(NCO_ADDR_INCH, 8'h00);
            wr(NCO_ADDR_INCL, 8'h01);
            wr(NCO_ADDR_CLK, 8'(n));
            wr(NCO_ADDR_CTRL, 8'h80);
            tk(3'(~(1 << n)));
            tk(3'(1 << n));
            rc(NCO_ADDR_ACCL, (n < 3) ? 8'h01 : 8'h00);
        end
        wr(NCO_ADDR_CTRL, 8'h00);
        wr(NCO_ADDR_CLK, 8'h00);
        wr(NCO_ADDR_ACCU, 8'h08);
        wr(NCO_ADDR_INCU, 8'h08);
        wr(NCO_ADDR_INCL, 8'h00);
        wr(NCO_ADDR_CTRL, 8'h80);
        tk(3'h1);
        rc(NCO_ADDR_ACCU, 8'h00);
        rc(NCO_ADDR_CTRL, 8'hA0);
        rc(NCO_ADDR_FLAG, 8'h01);
        tk(3'h1);
        rc(NCO_ADDR_CTRL, 8'hA0);
        tk(3'h1);
        rc(NCO_ADDR_CTRL, 8'h80);
        wr(NCO_ADDR_FLAG, 8'h00);
        rc(NCO_ADDR_FLAG, 8'h00);
        wr(NCO_ADDR_IEN, 8'h01);
        wr(NCO_ADDR_CTRL, 8'h90);
        @(negedge pclk);
        chk({7'h0, wave_out}, 8'h01);
        rc(NCO_ADDR_FLAG, 8'h01);
        wr(NCO_ADDR_IEN, 8'h07);
        @(negedge pclk);
        chk({7'h0, irq}, 8'h01);
        wr(NCO_ADDR_IEN, 8'h03);
        @(negedge pclk);
        chk({7'h0, irq}, 8'h00);
        wr(NCO_ADDR_IEN, 8'h07);
        wr(NCO_ADDR_FLAG, 8'h00);
        @(negedge pclk);
        chk({7'h0, irq}, 8'h00);
        wr(NCO_ADDR_IEN, 8'h00);
        // the new increment must wait for the second tick
        wr(NCO_ADDR_CTRL, 8'h00);
        wr(NCO_ADDR_INCU, 8'h00);
        wr(NCO_ADDR_INCL, 8'h01);
        wr(NCO_ADDR_CTRL, 8'h80);
        wr(NCO_ADDR_INCL, 8'h10);
        tk(3'h1);
        rc(NCO_ADDR_ACCL, 8'h01);
        tk(3'h1);
        xf(1'h0, NCO_ADDR_ACCL, 8'h00, a);
        tk(3'h1);
        rc(NCO_ADDR_ACCL, a + 8'h10);
        // overflow every 16 ticks; warm up, then count active ticks
        wr(NCO_ADDR_CTRL, 8'h00);
        wr(NCO_ADDR_INCU, 8'h01);
        wr(NCO_ADDR_INCL, 8'h00);
        for (n = 0; n < 6; n++) if (n != 4) begin
            wr(NCO_ADDR_CLK, 8'(n << 5));
            wr(NCO_ADDR_CTRL, 8'h81);
            repeat (16) tk(3'h1);
            cnt = 0;
            repeat (16) begin
                tk(3'h1);
                cnt += int'(wave_out === 1'h1);
            end
            chk(8'(cnt), (n == 5) ? 8'h10 : 8'(1 << n));
        end
        report_and_stop;
    end
endmodule
